/* File: src/spic_core.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spic_core
    import spic_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              irq_enable,
    input  wire logic              irq_ack,
    output logic                   irq_req,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe,
    input  wire logic              ss_n_in,
    input  wire logic              p02_in,
    output logic                   p03_out,
    output logic                   p03_oe
);

    // Byte addresses must fit the bus address
    if (ADDR_W < 10) begin : g_bad_addr
        $error("spic_core: ADDR_W must be at least 10");
    end

    localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'({IDX_CTRL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_DATA = ADDR_W'({IDX_DATA, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_STAT = ADDR_W'({IDX_STAT, 2'b00});

    logic [7:0]  ctrl_r;
    logic [7:0]  stat_en_r;     // Bits 3..0, pin enables
    logic        done_r;
    logic        write_collision_flag_r;
    logic        ss_rise_r;
    logic        clr_armed_r;
    logic [7:0]  data_buf_r;
    logic [7:0]  tx_r;
    logic [7:0]  rx_r;
    logic [7:0]  rx_nxt;
    logic        out_bit_r;
    logic [3:0]  edge_cnt_r;
    logic [6:0]  div_cnt_r;
    logic [6:0]  half;
    logic        sck_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        irq_r;
    spic_state_e state_r;

    logic ss_s1_r, ss_s2_r, ss_s3_r;
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic din_s1_r, din_s2_r;

    // Bus decode; one wait state so the answer is registered
    logic acc, wr, rd, hit_ctrl, hit_data, hit_stat, mapped;
    assign acc      = psel && penable && pready_r;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_data = (paddr == ADDR_DATA);
    assign hit_stat = (paddr == ADDR_STAT);
    assign mapped   = hit_ctrl || hit_data || hit_stat;

    logic en, master, lsb_first, idle_lvl, phase;
    logic two_wire, ss_ena, tx_ena, rx_ena;
    assign en        = ctrl_r[CTRL_UNIT_ON];
    assign master    = ctrl_r[CTRL_MASTER];
    assign lsb_first = ctrl_r[CTRL_LSB_FIRST];
    assign idle_lvl  = ctrl_r[CTRL_IDLE_LVL];
    assign phase     = ctrl_r[CTRL_PHASE];
    assign two_wire  = stat_en_r[STAT_TWO_WIRE];
    assign ss_ena    = stat_en_r[STAT_SS_ENA];
    assign tx_ena    = stat_en_r[STAT_TX_ENA];
    assign rx_ena    = stat_en_r[STAT_RX_ENA];

    // Internal select level replaces the pin when it is disabled
    logic ss_eff;
    assign ss_eff = ss_ena ? ss_s2_r : master;

    // Pin inputs pass two flops before any logic sees them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_s1_r  <= 1'b1;
            ss_s2_r  <= 1'b1;
            ss_s3_r  <= 1'b1;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            ss_s1_r  <= ss_n_in;
            ss_s2_r  <= ss_s1_r;
            ss_s3_r  <= ss_s2_r;
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            din_s1_r <= p02_in;
            din_s2_r <= din_s1_r;
        end
    end

    // Half period of SCK from rate and doubler
    always_comb begin
        case ({ctrl_r[CTRL_DOUBLER], ctrl_r[CTRL_RATE_HI],
               ctrl_r[CTRL_RATE_LO]})
            3'h0:    half = HALF_DIV4;
            3'h1:    half = HALF_DIV16;
            3'h2:    half = HALF_DIV64;
            3'h3:    half = HALF_DIV128;
            3'h4:    half = HALF_DIV2;
            3'h5:    half = HALF_DIV8;
            3'h6:    half = HALF_DIV32;
            default: half = HALF_DIV64;
        endcase
    end

    // Bit events: master from divider, slave from synchronised SCK
    logic busy, m_tick, s_edge, edge_ev, leading, sample_ev, setup_ev;
    logic last_ev, slave_hold, mode_fault, ss_rise_ev, start_ok;
    assign busy       = (state_r == SPIC_XFER);
    assign m_tick     = busy && master && (div_cnt_r == half - 7'h01);
    assign slave_hold = !master && ss_eff;
    assign s_edge     = busy && !master && !ss_eff
                        && (sck_s2_r != sck_s3_r);
    assign edge_ev    = en && (master ? m_tick : s_edge);
    assign leading    = !edge_cnt_r[0];
    assign sample_ev  = edge_ev && (leading != phase);
    assign setup_ev   = edge_ev && (leading == phase);
    assign last_ev    = edge_ev && (edge_cnt_r == LAST_EDGE);
    assign mode_fault = en && master && ss_ena && !ss_s2_r;
    assign ss_rise_ev = ss_ena && ss_s2_r && !ss_s3_r;
    assign start_ok   = wr && hit_data && en && !busy;

    // Receive shift, zero shifted in while reception is off
    logic din;
    assign din    = rx_ena && din_s2_r;
    assign rx_nxt = lsb_first ? {din, rx_r[7:1]}
                              : {rx_r[6:0], din};

    // Master capture waits two cycles: the pin bit at the SCK edge
    // reaches din_s2_r only then, which matters at fx/2 and fx/4
    logic [1:0] m_smp_r;
    logic [1:0] m_fin_r;
    logic       cap_ev, fin_ev;
    assign cap_ev = master ? m_smp_r[1] : sample_ev;
    assign fin_ev = master ? m_fin_r[1] : last_ev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_smp_r <= 2'b00;
            m_fin_r <= 2'b00;
        end else begin
            m_smp_r <= {m_smp_r[0], sample_ev && master};
            m_fin_r <= {m_fin_r[0], last_ev && master};
        end
    end

    // Transfer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SPIC_IDLE;
        end else begin
            case (state_r)
                SPIC_IDLE: begin
                    if (start_ok) begin
                        state_r <= SPIC_XFER;
                    end
                end
                SPIC_XFER: begin
                    if (!en || mode_fault || last_ev) begin
                        state_r <= SPIC_IDLE;
                    end
                end
                default: state_r <= SPIC_IDLE;
            endcase
        end
    end

    // Divider and edge count; slave count restarts while deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r  <= 7'h00;
            edge_cnt_r <= 4'h0;
        end else if (!busy || slave_hold) begin
            div_cnt_r  <= 7'h00;
            edge_cnt_r <= 4'h0;
        end else begin
            if (m_tick) begin
                div_cnt_r <= 7'h00;
            end else begin
                div_cnt_r <= div_cnt_r + 7'h01;
            end
            if (edge_ev) begin
                edge_cnt_r <= edge_cnt_r + 4'h1;
            end
        end
    end

    // Master SCK toggles per edge event and rests at the idle level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_r <= 1'b0;
        end else if (busy && master && en) begin
            if (m_tick) begin
                sck_r <= !sck_r;
            end
        end else begin
            sck_r <= idle_lvl;
        end
    end

    // Transmit shifter: first bit goes out at load for leading sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_r      <= DATA_RESET;
            out_bit_r <= 1'b0;
        end else if (start_ok) begin
            if (!phase) begin
                out_bit_r <= lsb_first ? pwdata[0] : pwdata[7];
                tx_r      <= lsb_first ? {1'b0, pwdata[7:1]}
                                       : {pwdata[6:0], 1'b0};
            end else begin
                tx_r <= pwdata[7:0];
            end
        end else if (setup_ev && edge_cnt_r != LAST_EDGE) begin
            out_bit_r <= lsb_first ? tx_r[0] : tx_r[7];
            tx_r      <= lsb_first ? {1'b0, tx_r[7:1]}
                                   : {tx_r[6:0], 1'b0};
        end
    end

    // Receive shifter; partial byte dropped while slave is deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_r <= DATA_RESET;
        end else if (start_ok || slave_hold) begin
            rx_r <= DATA_RESET;
        end else if (cap_ev) begin
            rx_r <= rx_nxt;
        end
    end

    // Received byte lands in the data buffer at the last edge, two cycles later as master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_buf_r <= DATA_RESET;
        end else if (fin_ev) begin
            data_buf_r <= cap_ev ? rx_nxt : rx_r;
        end
    end

    // Control register; a mode fault drops the port to slave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (wr && hit_ctrl && pstrb[0]) begin
                ctrl_r <= pwdata[7:0];
            end
            if (mode_fault) begin
                ctrl_r[CTRL_MASTER] <= 1'b0;
            end
        end
    end

    // Pin enable bits of the status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_en_r <= STAT_RESET;
        end else if (wr && hit_stat && pstrb[0]) begin
            stat_en_r <= {4'h0, pwdata[3:0]};
        end
    end

    // Status read arms the clear; the next data access fires it
    logic data_acc, flag_clr;
    assign data_acc = acc && hit_data;
    assign flag_clr = data_acc && clr_armed_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_armed_r <= 1'b0;
        end else if (rd && hit_stat) begin
            clr_armed_r <= 1'b1;
        end else if (data_acc) begin
            clr_armed_r <= 1'b0;
        end
    end

    // Done flag: a transfer end wins over a clear in the same cycle; a mode fault sets it only while it is clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (fin_ev || (mode_fault && !done_r)) begin
            done_r <= 1'b1;
        end else if (irq_enable && irq_ack) begin
            done_r <= 1'b0;
        end else if (!irq_enable && flag_clr) begin
            done_r <= 1'b0;
        end
    end

    // Collision flag; the colliding write is not loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag_r <= 1'b0;
        end else if (wr && hit_data && busy) begin
            write_collision_flag_r <= 1'b1;
        end else if (flag_clr) begin
            write_collision_flag_r <= 1'b0;
        end
    end

    // Select-rise flag; only a written zero clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_rise_r <= 1'b0;
        end else if (ss_rise_ev) begin
            ss_rise_r <= 1'b1;
        end else if (wr && hit_stat && pstrb[0]
                     && !pwdata[STAT_SS_RISE]) begin
            ss_rise_r <= 1'b0;
        end
    end

    // Interrupt request follows the done flag when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_enable && done_r;
        end
    end

    // APB answer registered in the wait cycle; unmapped gives an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
            if (psel && penable && !pready_r && !pwrite) begin
                if (hit_ctrl) begin
                    prdata_r <= {24'h00_0000, ctrl_r};
                end else if (hit_data) begin
                    prdata_r <= {24'h00_0000, data_buf_r};
                end else if (hit_stat) begin
                    prdata_r <= {24'h00_0000, done_r, write_collision_flag_r, ss_rise_r,
                                 1'b0, stat_en_r[3:0]};
                end else begin
                    prdata_r <= 32'h0000_0000;
                end
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Pins: SCK driven when unit on as master; data output released unless unit on and transmit enabled
    logic sck_oe_r, p03_oe_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_oe_r  <= 1'b0;
            p03_oe_r  <= 1'b0;
        end else begin
            sck_oe_r  <= en && master;
            // Two-wire master only receives; slave drives while selected
            p03_oe_r  <= en && tx_ena && !(master && two_wire)
                         && (master || !ss_eff);
        end
    end

    assign sck_out = sck_r;
    assign sck_oe  = sck_oe_r;
    assign p03_out = out_bit_r; // Moves at load in phase 0 and with setup edges
    assign p03_oe  = p03_oe_r;
    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;
    assign irq_req = irq_r;

endmodule
`default_nettype wire

/* File: src/spic_pkg.sv */
package spic_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hd2;
    localparam logic [7:0] IDX_DATA = 8'hd3;
    localparam logic [7:0] IDX_STAT = 8'hd4;

    // Control register fields
    localparam int CTRL_UNIT_ON   = 7;
    localparam int CTRL_LSB_FIRST = 6;
    localparam int CTRL_MASTER    = 5;
    localparam int CTRL_IDLE_LVL  = 4;
    localparam int CTRL_PHASE     = 3;
    localparam int CTRL_DOUBLER   = 2;
    localparam int CTRL_RATE_HI   = 1;
    localparam int CTRL_RATE_LO   = 0;

    // Status and pin enable fields
    localparam int STAT_DONE     = 7;
    localparam int STAT_WRITE_COLLISION_FLAG     = 6;
    localparam int STAT_SS_RISE  = 5;
    localparam int STAT_TWO_WIRE = 3;
    localparam int STAT_SS_ENA   = 2;
    localparam int STAT_TX_ENA   = 1;
    localparam int STAT_RX_ENA   = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // SCK half periods in fx cycles, indexed by {doubler, rate}
    localparam logic [6:0] HALF_DIV4   = 7'h02;
    localparam logic [6:0] HALF_DIV16  = 7'h08;
    localparam logic [6:0] HALF_DIV64  = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [6:0] HALF_DIV2   = 7'h01;
    localparam logic [6:0] HALF_DIV8   = 7'h04;
    localparam logic [6:0] HALF_DIV32  = 7'h10;

    // Last SCK edge index of a byte and last bit index
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [3:0] BITS_M1   = 4'h7;

    typedef enum logic [0:0] {
        SPIC_IDLE,
        SPIC_XFER
    } spic_state_e;

endpackage

/* File: test/spic_props.sv */
`timescale 1ns/1ps
`default_nettype none
module spic_props
    import spic_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq_enable,
    input wire logic              irq_ack,
    input wire logic              irq_req,
    input wire logic              sck_out,
    input wire logic              sck_oe,
    input wire logic              ss_n_in,
    input wire logic              p03_oe
);
    logic [7:0] ctl_sh;
    logic [7:0] st_sh;
    logic [4:0] tog;
    logic [7:0] gap;
    logic [7:0] half;
    logic       sck_q;
    logic       take;
    logic       wr_d;
    logic       chg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign take = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign wr_d = take && paddr == ADDR_W'({IDX_DATA, 2'b00});
    assign chg  = sck_out != sck_q;

    // Shadow of what software wrote; mode fault is not mirrored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_sh <= 8'h00;
            st_sh  <= 8'h00;
        end else if (take && paddr == ADDR_W'({IDX_CTRL, 2'b00})) begin
            ctl_sh <= pwdata[7:0];
        end else if (take && paddr == ADDR_W'({IDX_STAT, 2'b00})) begin
            st_sh <= pwdata[7:0];
        end
    end

    // Edge count per byte; 31 means disarmed so idle moves are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog   <= 5'h1f;
            gap   <= 8'h00;
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_out;
            gap   <= chg ? 8'h01 : gap + 8'h01;
            if (!sck_oe || (take && paddr == ADDR_W'({IDX_CTRL, 2'b00})))
                tog <= 5'h1f;
            else if (wr_d && tog[4])
                tog <= 5'h00;
            else if (chg && !tog[4])
                tog <= tog + 5'h01;
        end
    end

    // Expected half period in fx cycles for the selected rate
    always_comb begin
        case (ctl_sh[2:0])
            3'h0: half = 8'h02;
            3'h1: half = 8'h08;
            3'h2: half = 8'h20;
            3'h3: half = 8'h40;
            3'h4: half = 8'h01;
            3'h5: half = 8'h04;
            3'h6: half = 8'h10;
            default: half = 8'h20;
        endcase
    end

    sequence ack_s;
        irq_enable && irq_ack;
    endsequence

    unit_off_idle_a: assert property (!ctl_sh[7] |=> !sck_oe && !p03_oe)
        else $error("port active while unit off");
    clk_role_a: assert property (sck_oe |-> $past(ctl_sh[5] && ctl_sh[7]))
        else $error("SCK driven while not master");
    idle_level_a: assert property (wr_d && sck_oe && tog[4] |->
        sck_out == ctl_sh[CTRL_IDLE_LVL]) else $error("SCK idle level wrong");
    no_extra_edge_a: assert property (!(chg && tog == 5'h10))
        else $error("SCK moved after the byte ended");
    sck_rate_a: assert property (chg && tog != 5'h00 && !tog[4] |->
        gap == half) else $error("SCK half period wrong");
    tx_enable_a: assert property (p03_oe |-> $past(st_sh[STAT_TX_ENA]))
        else $error("data driven with transmit off");
    two_wire_a: assert property (ctl_sh[5] && ctl_sh[7] && st_sh[3]
        && ss_n_in |=> !p03_oe) else $error("p03 driven in two wire master");
    irq_gate_a: assert property (!irq_enable |=> !irq_req)
        else $error("request without enable");
    ack_clears_a: assert property (ack_s |-> ##2 !irq_req)
        else $error("request kept after service");
endmodule

bind spic_core spic_props #(.ADDR_W(ADDR_W)) spic_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .irq_enable(irq_enable),
    .irq_ack(irq_ack), .irq_req(irq_req), .sck_out(sck_out),
    .sck_oe(sck_oe), .ss_n_in(ss_n_in), .p03_oe(p03_oe)
);
`default_nettype wire

/* File: test/spic_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spic_slave_model (
    input wire logic       sck,
    input wire logic       flip,
    input wire logic       sel_n,
    input wire logic       mosi,
    input wire logic [7:0] tx_byte,
    output logic           miso,
    output logic [7:0]     rx_byte
);
    logic [3:0] cnt = 4'h0;
    wire logic  smp;

    // Sample edge is the leading edge for phase 0, trailing for phase 1
    assign smp = sck ^ flip;

    initial miso = 1'b1;

    // Capture on the sample edge, MSB first
    always @(posedge smp or posedge sel_n) begin
        if (sel_n) begin
            cnt <= 4'h0;
        end else begin
            rx_byte <= {rx_byte[6:0], mosi};
            cnt     <= cnt + 4'h1;
        end
    end

    // Setup edge; a released line shows the inverse so stale bits fail
    always @(negedge smp or negedge sel_n or posedge sel_n) begin
        if (sel_n)
            miso <= ~miso;
        else if (!cnt[3])
            miso <= tx_byte[~cnt[2:0]];
    end
endmodule
`default_nettype wire

/* File: test/spi_control_and_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_control_and_status_tb_top
    import spic_pkg::*;
;
    localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [11:0] A_DATA = {2'b00, IDX_DATA, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_STAT, 2'b00};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq_enable;
    logic        irq_ack;
    logic        irq_req;
    logic        sck_out;
    logic        sck_oe;
    logic        ss_n_in;
    logic        p02_in;
    logic        p03_out;
    logic        p03_oe;
    logic        sel_n;
    logic        flip;
    logic        err;
    logic [7:0]  mtx;
    logic [7:0]  mrx;
    logic [7:0]  rv;
    int          num_errors;
    int          compares;

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    spic_core spic_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .irq_enable(irq_enable), .irq_ack(irq_ack), .irq_req(irq_req),
        .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe),
        .ss_n_in(ss_n_in), .p02_in(p02_in), .p03_out(p03_out),
        .p03_oe(p03_oe)
    );

    // Undriven clock line rests low, the model is deselected then
    spic_slave_model spic_slave_model_inst (
        .sck(sck_oe & sck_out), .flip(flip), .sel_n(sel_n),
        .mosi(p03_out), .tx_byte(mtx), .miso(p02_in), .rx_byte(mrx)
    );

    task automatic conclude;
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
        end
    endtask

    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int k = 0; k < 8; k++)
            rev[k] = v[7-k];
    endfunction

    // Request held until pready is seen at a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(q, e);
    endtask

    // Polling status also arms the status-then-data flag clear
    task automatic wait_done;
        int n;
        logic [7:0] s;
        n = 0;
        do begin
            rd(A_STAT, s);
            n++;
        end while (s[7] !== 1'b1 && n < 600);
        if (s[7] !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t: done flag never set", $time);
        end
    endtask

    task automatic t_regs;
        rchk(A_CTRL, 8'h00);
        rchk(A_DATA, 8'h00);
        rchk(A_STAT, 8'h00);
        rd(12'h000, rv);
        chk({7'h00, err}, 8'h01);
        wr(A_CTRL, 8'h20);
        wr(A_DATA, 8'h96);
        repeat (40) @(posedge pclk);
        rchk(A_STAT, 8'h00);
    endtask

    // Every clock mode, bit order and rate code in turn
    task automatic t_modes;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] m;
        wr(A_STAT, 8'h03);
        for (int i = 0; i < 8; i++) begin
            c = {1'b1, i[0] ^ i[1], 1'b1, i[0], i[1], i[2:0]};
            d = 8'ha5 ^ 8'(i);
            m = 8'h3c + 8'(i);
            flip <= c[4] ^ c[3];
            mtx  <= m;
            wr(A_CTRL, c);
            rchk(A_CTRL, c);
            sel_n <= 1'b0;
            wr(A_DATA, d);
            wait_done;
            sel_n <= 1'b1;
            chk(mrx, c[6] ? rev(d) : d);
            chk({7'h00, sck_out}, {7'h00, c[4]});
            rchk(A_DATA, c[6] ? rev(m) : m);
            rchk(A_STAT, 8'h03);
        end
    endtask

    task automatic t_coll;
        flip <= 1'b0;
        mtx  <= 8'h77;
        wr(A_CTRL, 8'ha0);
        sel_n <= 1'b0;
        wr(A_DATA, 8'h11);
        wr(A_DATA, 8'h22);
        rd(A_STAT, rv);
        chk(rv & 8'h40, 8'h40);
        wait_done;
        sel_n <= 1'b1;
        chk(mrx, 8'h11);
        rchk(A_DATA, 8'h77);
        wr(A_STAT, 8'hc3);
        rchk(A_STAT, 8'h03);
    endtask

    task automatic t_irq;
        int n;
        irq_enable <= 1'b1;
        sel_n <= 1'b0;
        wr(A_DATA, 8'h5c);
        n = 0;
        while (irq_req !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        sel_n <= 1'b1;
        chk({7'h00, irq_req}, 8'h01);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({7'h00, irq_req}, 8'h00);
        rchk(A_STAT, 8'h03);
        irq_enable <= 1'b0;
    endtask

    task automatic t_off;
        mtx <= 8'hc6;
        wr(A_STAT, 8'h0b);
        sel_n <= 1'b0;
        wr(A_DATA, 8'h3a);
        wait_done;
        sel_n <= 1'b1;
        chk({7'h00, p03_oe}, 8'h00);
        rchk(A_DATA, 8'hc6);
        mtx <= 8'hff;
        wr(A_STAT, 8'h00);
        sel_n <= 1'b0;
        wr(A_DATA, 8'h3a);
        wait_done;
        sel_n <= 1'b1;
        chk({7'h00, p03_oe}, 8'h00);
        rchk(A_DATA, 8'h00);
    endtask

    // Select rise as slave, then write-one and write-zero
    task automatic t_ss;
        wr(A_CTRL, 8'h80);
        wr(A_STAT, 8'h04);
        ss_n_in <= 1'b0;
        repeat (6) @(posedge pclk);
        ss_n_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk(A_STAT, 8'h24);
        wr(A_STAT, 8'h24);
        rchk(A_STAT, 8'h24);
        wr(A_STAT, 8'h04);
        rchk(A_STAT, 8'h04);
    endtask

    task automatic t_fault;
        wr(A_CTRL, 8'ha0);
        ss_n_in <= 1'b0;
        repeat (6) @(posedge pclk);
        rchk(A_CTRL, 8'h80);
        rd(A_STAT, rv);
        chk(rv & 8'h80, 8'h80);
        ss_n_in <= 1'b1;
    endtask

    initial begin
        num_errors = 0;
        compares   = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h00000000;
        irq_enable = 1'b0;
        irq_ack    = 1'b0;
        ss_n_in    = 1'b1;
        sel_n      = 1'b1;
        flip       = 1'b0;
        mtx        = 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_modes;
        t_coll;
        t_irq;
        t_off;
        t_ss;
        t_fault;
        conclude;
    end

    // Slowest rate needs about 1100 cycles a byte; twelve bytes fit easily
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        conclude;
    end
endmodule
`default_nettype wire
